// ### phy_status_led_map.vh
// register offsets, field positions, reset values and timing counts
`ifndef PHY_STATUS_LED_MAP_VH
`define PHY_STATUS_LED_MAP_VH

// ----------------------------------------------------------------------
// register byte offsets (apb, one word each)
// ----------------------------------------------------------------------
`define OFF_STATUS      12'h000
`define OFF_PAGE        12'h004
`define OFF_LED_CFG     12'h008
`define OFF_LINK_IN     12'h00C
`define OFF_STRAP       12'h010

// ----------------------------------------------------------------------
// status word bit positions
// ----------------------------------------------------------------------
`define ST_AN_DONE      0
`define ST_LINK_STD     1
`define ST_LINK_SEC     2
`define ST_SPEED        3
`define ST_DUPLEX       4
`define ST_POL_REV      5

// ----------------------------------------------------------------------
// page word bit positions
// ----------------------------------------------------------------------
`define PG_RECEIVED     0
`define PG_BASE         1
`define PG_ALT_MODE     2

// ----------------------------------------------------------------------
// led config fields: sel a [15:12], b [11:8], c [7:4], stretch [3:2], en [1]
// ----------------------------------------------------------------------
`define CFG_SEL_A_HI    15
`define CFG_SEL_B_HI    11
`define CFG_SEL_C_HI    7
`define CFG_STR_HI      3
`define CFG_STR_LO      2
`define CFG_STR_EN      1
`define LED_CFG_RESET   16'h0000

// ----------------------------------------------------------------------
// led source selections
// ----------------------------------------------------------------------
`define SEL_COL         4'h0
`define SEL_DUPLEX      4'h1
`define SEL_LINK        4'h2
`define SEL_SPEED       4'h3
`define SEL_RX_ACT      4'h4
`define SEL_TX_ACT      4'h5
`define SEL_LINK_ACT    4'hD

// ----------------------------------------------------------------------
// timing: clock period in ns, times in ms
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS   10
`define POWERUP_MS      1000
`define STRETCH_A_MS    30
`define STRETCH_B_MS    60
`define STRETCH_C_MS    100
`define POWERUP_CYC     (`POWERUP_MS * 1000000 / `CLK_PERIOD_NS)
`define STRETCH_A_CYC   (`STRETCH_A_MS * 1000000 / `CLK_PERIOD_NS)
`define STRETCH_B_CYC   (`STRETCH_B_MS * 1000000 / `CLK_PERIOD_NS)
`define STRETCH_C_CYC   (`STRETCH_C_MS * 1000000 / `CLK_PERIOD_NS)

`endif

// ### led_stretch.v
// one led channel: edge detect and pulse stretch timer
`timescale 1ns/100ps
module led_stretch (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        event_i,
  input  wire        enable_i,
  input  wire [31:0] limit_i,
  output reg         led_o
);
  reg [31:0] count_reg;
  reg        prev_reg;
  reg        active_reg;
  wire       edge_seen = event_i & ~prev_reg;
  wire       expire    = active_reg & (count_reg >= limit_i);

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg  <= 32'h0000_0000;
      prev_reg   <= 1'b0;
      active_reg <= 1'b0;
      led_o      <= 1'b0;
    end else if (!enable_i) begin
      count_reg  <= 32'h0000_0000;
      prev_reg   <= event_i;
      active_reg <= 1'b0;
      led_o      <= event_i;
    end else begin
      // clearing prev at expiry makes a held level give a fresh edge
      prev_reg <= expire ? 1'b0 : event_i;
      if (edge_seen) begin
        count_reg  <= 32'h0000_0001;
        active_reg <= 1'b1;
      end else if (expire) begin
        active_reg <= 1'b0;
      end else if (active_reg) begin
        count_reg <= count_reg + 32'h0000_0001;
      end
      // a level still present at expiry keeps the led lit into its fresh edge
      led_o <= edge_seen | (active_reg & (~expire | event_i));
    end
  end
endmodule // led_stretch

// ### phy_status_led_monitor.v
// status monitor and led drivers with apb register access
//
// Contract
// - auto-negotiation complete bit set when negotiation finishes
// - standard and secondary link bits set once link established
// - resolved speed and duplex readable in two status bits
// - polarity-reversed bit set on inverted 10 Mbps receive polarity
// - normal mode: page-received flag stays set until read
// - alternate mode: page-received cleared at each new negotiation start
// - base-page flag set when a base page is received, held until read
// - reading clears page-received and base-page flags
// - all three leds on for about one second after reset
// - each led selects collision, duplex, link, speed, rx or tx activity
// - led a link-activity code: led off when link down, still blinks on activity
// - led a link-activity code: on while link up, blinks at stretch interval
// - optional pulse stretch of 30, 60 or 100 ms
// - event edge starts stretch timer, led held until expiry
// - new edge before expiry restarts timer
// - expiry with level still present rearms edge detector
// - led pins sampled as straps; pull and polarity adapt to circuit
`timescale 1ns/100ps
`include "phy_status_led_map.vh"
module phy_status_led_monitor #(
  parameter [31:0] POWERUP_CYCLES = `POWERUP_CYC
) (
  input  wire        MCLK_I,
  input  wire        RST_I,
  input  wire        PSEL_I,
  input  wire        PENABLE_I,
  input  wire        PWRITE_I,
  input  wire [11:0] PADDR_I,
  input  wire [31:0] PWDATA_I,
  output reg  [31:0] PRDATA_O,
  output reg         PREADY_O,
  output reg         PSLVERR_O,
  input  wire        AN_DONE_I,
  input  wire        LINK_UP_I,
  input  wire        SPEED_100_I,
  input  wire        FULL_DUPLEX_I,
  input  wire        POL_REV_I,
  input  wire        PAGE_RX_I,
  input  wire        BASE_PAGE_I,
  input  wire        AN_START_I,
  input  wire        COL_I,
  input  wire        RX_ACT_I,
  input  wire        TX_ACT_I,
  input  wire        LED_A_STRAP_I,
  input  wire        LED_B_STRAP_I,
  input  wire        LED_C_STRAP_I,
  output reg         LED_A_O,
  output reg         LED_A_OE_O,
  output reg         LED_B_O,
  output reg         LED_B_OE_O,
  output reg         LED_C_O,
  output reg         LED_C_OE_O,
  output reg  [2:0]  STRAP_PULL_UP_O
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------
  function [31:0] stretch_limit;
    input [1:0] code;
    begin
      case (code)
        2'h0:    stretch_limit = `STRETCH_A_CYC;
        2'h1:    stretch_limit = `STRETCH_B_CYC;
        default: stretch_limit = `STRETCH_C_CYC;
      endcase
    end
  endfunction

  function led_source;
    input [3:0] sel;
    input       col;
    input       dup;
    input       link;
    input       spd;
    input       rxa;
    input       txa;
    begin
      case (sel)
        `SEL_COL:    led_source = col;
        `SEL_DUPLEX: led_source = dup;
        `SEL_LINK:   led_source = link;
        `SEL_SPEED:  led_source = spd;
        `SEL_RX_ACT: led_source = rxa;
        `SEL_TX_ACT: led_source = txa;
        default:     led_source = 1'b0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  localparam PU_RUN  = 1'b0;
  localparam PU_DONE = 1'b1;

  reg        pu_state_reg;
  reg [31:0] pu_count_reg;
  reg        strap_taken_reg;
  reg [2:0]  strap_reg;
  reg        page_rx_reg;
  reg        base_page_reg;
  reg        alt_mode_reg;
  reg [15:0] led_cfg_reg;
  reg [5:0]  status_reg;
  reg [31:0] rdata_next;
  reg        err_next;
  reg [31:0] blink_count_reg;
  reg        blink_reg;

  wire        access  = PSEL_I & PENABLE_I & PREADY_O;
  wire        rd_page = access & ~PWRITE_I & (PADDR_I == `OFF_PAGE);
  wire        any_act = RX_ACT_I | TX_ACT_I;
  wire [31:0] limit   = stretch_limit(led_cfg_reg[`CFG_STR_HI:`CFG_STR_LO]);
  wire        str_en  = led_cfg_reg[`CFG_STR_EN];
  wire [3:0]  sel_a   = led_cfg_reg[`CFG_SEL_A_HI:`CFG_SEL_A_HI-3];
  wire [3:0]  sel_b   = led_cfg_reg[`CFG_SEL_B_HI:`CFG_SEL_B_HI-3];
  wire [3:0]  sel_c   = led_cfg_reg[`CFG_SEL_C_HI:`CFG_SEL_C_HI-3];
  wire        link_act_a = (sel_a == `SEL_LINK_ACT);
  wire        src_a = link_act_a ? any_act : led_source(sel_a, COL_I, FULL_DUPLEX_I,
                      LINK_UP_I, SPEED_100_I, RX_ACT_I, TX_ACT_I);
  wire        src_b = led_source(sel_b, COL_I, FULL_DUPLEX_I, LINK_UP_I,
                      SPEED_100_I, RX_ACT_I, TX_ACT_I);
  wire        src_c = led_source(sel_c, COL_I, FULL_DUPLEX_I, LINK_UP_I,
                      SPEED_100_I, RX_ACT_I, TX_ACT_I);
  wire        str_a;
  wire        str_b;
  wire        str_c;
  wire        lit_a;

  // ----------------------------------------------------------------------
  // status capture
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      status_reg <= 6'h00;
    end else begin
      status_reg[`ST_AN_DONE]  <= AN_DONE_I;
      status_reg[`ST_LINK_STD] <= LINK_UP_I;
      status_reg[`ST_LINK_SEC] <= LINK_UP_I;
      status_reg[`ST_SPEED]    <= SPEED_100_I;
      status_reg[`ST_DUPLEX]   <= FULL_DUPLEX_I;
      status_reg[`ST_POL_REV]  <= POL_REV_I & ~SPEED_100_I;
    end
  end

  // ----------------------------------------------------------------------
  // page flags: set wins over read clear
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      page_rx_reg   <= 1'b0;
      base_page_reg <= 1'b0;
    end else begin
      if (PAGE_RX_I)
        page_rx_reg <= 1'b1;
      else if (rd_page)
        page_rx_reg <= 1'b0;
      else if (alt_mode_reg & AN_START_I)
        page_rx_reg <= 1'b0;
      if (PAGE_RX_I & BASE_PAGE_I)
        base_page_reg <= 1'b1;
      else if (rd_page)
        base_page_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // power-up lamp test and strap capture
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      pu_state_reg    <= PU_RUN;
      pu_count_reg    <= 32'h0000_0000;
      strap_taken_reg <= 1'b0;
      strap_reg       <= 3'h0;
    end else begin
      if (!strap_taken_reg) begin
        strap_reg       <= {LED_C_STRAP_I, LED_B_STRAP_I, LED_A_STRAP_I};
        strap_taken_reg <= 1'b1;
      end
      case (pu_state_reg)
        PU_RUN: begin
          if (pu_count_reg >= POWERUP_CYCLES - 32'h0000_0001)
            pu_state_reg <= PU_DONE;
          else
            pu_count_reg <= pu_count_reg + 32'h0000_0001;
        end
        PU_DONE: pu_state_reg <= PU_DONE;
        default: pu_state_reg <= PU_DONE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // stretch channels
  // ----------------------------------------------------------------------
  led_stretch u_str_a (
    .clk_i    (MCLK_I),
    .rst_i    (RST_I),
    .event_i  (src_a),
    .enable_i (str_en),
    .limit_i  (limit),
    .led_o    (str_a)
  );
  led_stretch u_str_b (
    .clk_i    (MCLK_I),
    .rst_i    (RST_I),
    .event_i  (src_b),
    .enable_i (str_en),
    .limit_i  (limit),
    .led_o    (str_b)
  );
  led_stretch u_str_c (
    .clk_i    (MCLK_I),
    .rst_i    (RST_I),
    .event_i  (src_c),
    .enable_i (str_en),
    .limit_i  (limit),
    .led_o    (str_c)
  );

  // ----------------------------------------------------------------------
  // link-activity blink phase: toggles each stretch interval of activity
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      blink_count_reg <= 32'h0000_0000;
      blink_reg       <= 1'b0;
    end else if (!str_a) begin
      blink_count_reg <= 32'h0000_0000;
      blink_reg       <= 1'b0;
    end else if (blink_count_reg >= limit - 32'h0000_0001) begin
      blink_count_reg <= 32'h0000_0000;
      blink_reg       <= ~blink_reg;
    end else begin
      blink_count_reg <= blink_count_reg + 32'h0000_0001;
    end
  end

  // link up: lit except while str_a is high and blink_reg is low; link down: lit while str_a is high and blink_reg is low
  assign lit_a = link_act_a ? (LINK_UP_I ? (~str_a | blink_reg) : (str_a & ~blink_reg))
                            : str_a;

  // ----------------------------------------------------------------------
  // led pins: strap high means led to supply, drive low to light
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      LED_A_O         <= 1'b0;
      LED_B_O         <= 1'b0;
      LED_C_O         <= 1'b0;
      LED_A_OE_O      <= 1'b0;
      LED_B_OE_O      <= 1'b0;
      LED_C_OE_O      <= 1'b0;
      STRAP_PULL_UP_O <= 3'h0;
    end else begin
      STRAP_PULL_UP_O <= strap_reg;
      LED_A_OE_O      <= strap_taken_reg;
      LED_B_OE_O      <= strap_taken_reg;
      LED_C_OE_O      <= strap_taken_reg;
      LED_A_O <= strap_reg[0] ^ ((pu_state_reg == PU_RUN) | lit_a);
      LED_B_O <= strap_reg[1] ^ ((pu_state_reg == PU_RUN) | str_b);
      LED_C_O <= strap_reg[2] ^ ((pu_state_reg == PU_RUN) | str_c);
    end
  end

  // ----------------------------------------------------------------------
  // apb slave: no wait states, pready high in access phase
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h0000_0000;
    err_next   = 1'b0;
    case (PADDR_I)
      `OFF_STATUS:  rdata_next = {26'h0, status_reg};
      `OFF_PAGE:    rdata_next = {29'h0, alt_mode_reg, base_page_reg, page_rx_reg};
      `OFF_LED_CFG: rdata_next = {16'h0, led_cfg_reg};
      `OFF_LINK_IN: rdata_next = {31'h0, LINK_UP_I};
      `OFF_STRAP:   rdata_next = {29'h0, strap_reg};
      default:      err_next   = 1'b1;
    endcase
  end

  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O     <= 1'b0;
      PRDATA_O     <= 32'h0000_0000;
      PSLVERR_O    <= 1'b0;
      alt_mode_reg <= 1'b0;
      led_cfg_reg  <= `LED_CFG_RESET;
    end else begin
      PREADY_O  <= PSEL_I & ~PENABLE_I;
      PSLVERR_O <= PSEL_I & ~PENABLE_I & err_next;
      PRDATA_O  <= (PSEL_I & ~PENABLE_I & ~PWRITE_I) ? rdata_next : 32'h0000_0000;
      if (access & PWRITE_I & (PADDR_I == `OFF_LED_CFG))
        led_cfg_reg <= PWDATA_I[15:0];
      if (access & PWRITE_I & (PADDR_I == `OFF_PAGE))
        alt_mode_reg <= PWDATA_I[`PG_ALT_MODE];
    end
  end

endmodule // phy_status_led_monitor

// ### phy_status_led_properties.sv
// concurrent checks on the status monitor's apb and led ports
`timescale 1ns/100ps
module phy_status_led_checker #(
  parameter [31:0] POWERUP_CYCLES = 32'd50
) (
  input wire        MCLK_I,
  input wire        RST_I,
  input wire        PSEL_I,
  input wire        PENABLE_I,
  input wire        PWRITE_I,
  input wire [11:0] PADDR_I,
  input wire [31:0] PRDATA_O,
  input wire        PREADY_O,
  input wire        PSLVERR_O,
  input wire        AN_DONE_I,
  input wire        LINK_UP_I,
  input wire        SPEED_100_I,
  input wire        FULL_DUPLEX_I,
  input wire        LED_A_STRAP_I,
  input wire        LED_B_STRAP_I,
  input wire        LED_C_STRAP_I,
  input wire        LED_A_O,
  input wire        LED_A_OE_O,
  input wire        LED_B_O,
  input wire        LED_B_OE_O,
  input wire        LED_C_O,
  input wire        LED_C_OE_O,
  input wire [2:0]  STRAP_PULL_UP_O
);
  logic [31:0] cnt;
  wire         rd_st = PREADY_O && !PWRITE_I && PADDR_I == 12'h000;
  // ----------------------------------------------------------------------
  // cycles since reset release, saturating
  // ----------------------------------------------------------------------
  always @(posedge MCLK_I or posedge RST_I) begin
    if (RST_I)
      cnt <= 32'h0;
    else if (cnt < POWERUP_CYCLES + 32'h8)
      cnt <= cnt + 32'h1;
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  sequence calm_read;
    $stable({AN_DONE_I, LINK_UP_I, SPEED_100_I, FULL_DUPLEX_I})[*4] ##0 rd_st;
  endsequence
  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  a_ready_after_setup: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (PREADY_O |=> !PREADY_O)
    else $error("ready longer than one cycle");
  a_unmapped_error: assert property (PREADY_O |->
    PSLVERR_O == (PADDR_I > 12'h010 || PADDR_I[1:0] != 2'b00))
    else $error("error response wrong");
  a_an_done_read: assert property (calm_read |-> PRDATA_O[0] == AN_DONE_I)
    else $error("negotiation done bit wrong");
  a_link_bits_agree: assert property (calm_read |-> PRDATA_O[2:1] == {2{LINK_UP_I}})
    else $error("link bits wrong");
  a_speed_duplex_read: assert property (calm_read |->
    PRDATA_O[4:3] == {FULL_DUPLEX_I, SPEED_100_I})
    else $error("speed or duplex bit wrong");
  a_pol_only_slow: assert property (rd_st |-> !(PRDATA_O[5] && PRDATA_O[3]))
    else $error("polarity flag at fast speed");
  a_lamp_test_on: assert property (cnt >= 3 && cnt <= POWERUP_CYCLES |->
    {LED_C_O, LED_B_O, LED_A_O} == ~STRAP_PULL_UP_O
    && LED_A_OE_O && LED_B_OE_O && LED_C_OE_O)
    else $error("lamp test not lit");
  a_strap_capture: assert property (cnt >= 2 |->
    STRAP_PULL_UP_O == {LED_C_STRAP_I, LED_B_STRAP_I, LED_A_STRAP_I})
    else $error("strap capture wrong");
endmodule // phy_status_led_checker

// ### board_led_model.sv
// board led circuit on one shared led and strap pin
`timescale 1ns/100ps
module board_led_model #(
  parameter bit PULL_HIGH = 1'b1
) (
  input  wire  led_i,
  input  wire  oe_i,
  output logic strap_o,
  output logic lit_o
);
  // released pin rests at the board pull
  wire pin = oe_i ? led_i : PULL_HIGH;
  assign strap_o = PULL_HIGH;
  assign lit_o   = oe_i && (pin ^ PULL_HIGH);
endmodule // board_led_model

// ### phy_status_led_monitor_tb_top.sv
// top bench: apb software, board leds, random status and activity
`timescale 1ns/100ps
module phy_status_led_monitor_tb_top;
  logic        MCLK_I = 1'b0;
  logic        RST_I = 1'b1;
  logic        PSEL_I = 1'b0, PENABLE_I = 1'b0, PWRITE_I = 1'b0;
  logic [11:0] PADDR_I = 12'h000;
  logic [31:0] PWDATA_I = 32'h0;
  logic        AN_DONE_I = 1'b0, LINK_UP_I = 1'b0, SPEED_100_I = 1'b0;
  logic        FULL_DUPLEX_I = 1'b0, POL_REV_I = 1'b0, AN_START_I = 1'b0;
  logic        PAGE_RX_I = 1'b0, BASE_PAGE_I = 1'b0;
  logic        COL_I = 1'b0, RX_ACT_I = 1'b0, TX_ACT_I = 1'b0;
  wire  [31:0] PRDATA_O;
  wire         PREADY_O, PSLVERR_O, LED_A_STRAP_I, LED_B_STRAP_I, LED_C_STRAP_I;
  wire         LED_A_O, LED_A_OE_O, LED_B_O, LED_B_OE_O, LED_C_O, LED_C_OE_O;
  wire  [2:0]  STRAP_PULL_UP_O;
  wire  [2:0]  lit;
  int          err_count = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #5 MCLK_I = ~MCLK_I;

  phy_status_led_monitor #(.POWERUP_CYCLES(32'd50)) uut (.*);
  board_led_model #(.PULL_HIGH(1'b1)) led_a (.led_i(LED_A_O), .oe_i(LED_A_OE_O),
    .strap_o(LED_A_STRAP_I), .lit_o(lit[0]));
  board_led_model #(.PULL_HIGH(1'b0)) led_b (.led_i(LED_B_O), .oe_i(LED_B_OE_O),
    .strap_o(LED_B_STRAP_I), .lit_o(lit[1]));
  board_led_model #(.PULL_HIGH(1'b1)) led_c (.led_i(LED_C_O), .oe_i(LED_C_OE_O),
    .strap_o(LED_C_STRAP_I), .lit_o(lit[2]));

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge MCLK_I);
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge MCLK_I);
    PSEL_I <= 1'b1;
    PWRITE_I <= wr;
    PADDR_I <= a;
    PWDATA_I <= wd;
    @(posedge MCLK_I);
    PENABLE_I <= 1'b1;
    @(posedge MCLK_I);
    while (PREADY_O !== 1'b1 && n < 20) begin
      n++;
      @(posedge MCLK_I);
    end
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I <= 1'b0;
    PENABLE_I <= 1'b0;
    if (n >= 20)
      err_count++;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    apb(1'b0, a, 32'h0, d, e);
    check(name, exp, d);
  endtask

  task automatic pulse_in(input logic pg, input logic base, input logic an);
    @(posedge MCLK_I);
    PAGE_RX_I <= pg;
    BASE_PAGE_I <= base;
    AN_START_I <= an;
    @(posedge MCLK_I);
    PAGE_RX_I <= 1'b0;
    AN_START_I <= 1'b0;
  endtask

  function automatic logic [31:0] exp_status(input logic [4:0] s);
    return {26'h0, s[4] & ~s[2], s[3], s[2], s[1], s[1], s[0]};
  endfunction

  function automatic logic src(input int sel, input logic [4:0] s, input logic [2:0] a);
    case (sel)
      0: return a[0];
      1: return s[3];
      2: return s[1];
      3: return s[2];
      4: return a[1];
      5: return a[2];
      default: return 1'b0;
    endcase
  endfunction

  always @(posedge MCLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    int          seed, i;
    logic [31:0] s, r, d;
    logic        e;
    seed = 51692;
    repeat (8) @(posedge MCLK_I);
    RST_I <= 1'b0;
    cyc(5);
    @(negedge MCLK_I);
    check("lamp_on", 32'h7, {29'h0, lit});
    check("straps", 32'h5, {29'h0, STRAP_PULL_UP_O});
    rd_chk("strap_read", 12'h010, 32'h5);
    cyc(60);
    @(negedge MCLK_I);
    check("lamp_off", 32'h0, {29'h0, lit});
    for (i = 0; i < 12; i++) begin
      s = $random(seed);
      @(posedge MCLK_I);
      {POL_REV_I, FULL_DUPLEX_I, SPEED_100_I, LINK_UP_I, AN_DONE_I} <= s[4:0];
      cyc(4);
      rd_chk("status", 12'h000, exp_status(s[4:0]));
      rd_chk("link_in", 12'h00C, {31'h0, s[1]});
    end
    pulse_in(1'b1, 1'b1, 1'b0);
    rd_chk("page_base", 12'h004, 32'h3);
    rd_chk("page_clear", 12'h004, 32'h0);
    pulse_in(1'b1, 1'b0, 1'b0);
    pulse_in(1'b0, 1'b0, 1'b1);
    rd_chk("page_kept", 12'h004, 32'h1);
    apb(1'b1, 12'h004, 32'h4, d, e);
    pulse_in(1'b1, 1'b0, 1'b0);
    pulse_in(1'b0, 1'b0, 1'b1);
    rd_chk("page_alt", 12'h004, 32'h4);
    apb(1'b0, 12'h020, 32'h0, d, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_data", 32'h0, d);
    for (i = 0; i < 12; i++) begin
      s = $random(seed);
      r = $random(seed);
      apb(1'b1, 12'h008, {16'h0, 4'(i % 6), 4'((i + 1) % 6), 4'((i + 2) % 6), 4'h0}, d, e);
      {POL_REV_I, FULL_DUPLEX_I, SPEED_100_I, LINK_UP_I, AN_DONE_I} <= s[4:0];
      {TX_ACT_I, RX_ACT_I, COL_I} <= r[2:0];
      cyc(4);
      @(negedge MCLK_I);
      check("led_select", {29'h0, src((i + 2) % 6, s[4:0], r[2:0]),
        src((i + 1) % 6, s[4:0], r[2:0]), src(i % 6, s[4:0], r[2:0])}, {29'h0, lit});
    end
    apb(1'b1, 12'h008, 32'h0000_D000, d, e);
    rd_chk("led_cfg", 12'h008, 32'h0000_D000);
    {TX_ACT_I, RX_ACT_I, COL_I} <= 3'h0;
    LINK_UP_I <= 1'b1;
    cyc(4);
    @(negedge MCLK_I);
    check("link_act_up", 32'h1, {31'h0, lit[0]});
    @(posedge MCLK_I);
    LINK_UP_I <= 1'b0;
    cyc(4);
    @(negedge MCLK_I);
    check("link_act_down", 32'h0, {31'h0, lit[0]});
    @(posedge MCLK_I);
    RX_ACT_I <= 1'b1;
    cyc(4);
    @(negedge MCLK_I);
    check("link_act_down_blink", 32'h1, {31'h0, lit[0]});
    @(posedge MCLK_I);
    LINK_UP_I <= 1'b1;
    cyc(4);
    @(negedge MCLK_I);
    check("link_act_up_blink", 32'h0, {31'h0, lit[0]});
    @(posedge MCLK_I);
    RX_ACT_I <= 1'b0;
    cyc(2);
    apb(1'b1, 12'h008, 32'h0000_4002, d, e);
    RX_ACT_I <= 1'b1;
    @(posedge MCLK_I);
    RX_ACT_I <= 1'b0;
    cyc(200);
    @(negedge MCLK_I);
    check("stretch_hold", 32'h1, {31'h0, lit[0]});
    tally_and_finish();
  end
endmodule // phy_status_led_monitor_tb_top

bind phy_status_led_monitor phy_status_led_checker #(.POWERUP_CYCLES(POWERUP_CYCLES)) chk (.*);
